/* bench/pcot_rc_model.sv */
// root complex model: tlp sink that can hold off the translator
// assumes tlp handshake on clk_sys, valid held until ready
`timescale 1ns/1ns
`default_nettype none
module pcot_rc_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic stall,
  input wire logic tlp_valid,
  input wire pcot_pkg::pcot_tlp_s tlp,
  output var logic tlp_ready,
  output var pcot_pkg::pcot_tlp_s last_tlp,
  output var logic [7:0] n_tlp
);
  import pcot_pkg::*;
  // sink refuses while stalled
  always_comb tlp_ready = ~stall;
  // memory request taken from the link
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      last_tlp <= '0;
      n_tlp <= 8'h00;
    end else if (tlp_valid && tlp_ready) begin
      last_tlp <= tlp;
      n_tlp <= n_tlp + 8'h01;
    end
  end
endmodule : pcot_rc_model
`default_nettype wire

/* bench/pcot_top_tb.sv */
// self-checking bench for the outbound translation and power block
// assumes pcot_rc_model as tlp sink and a 250 MHz clk_sys
`timescale 1ns/1ns
`default_nettype none
`include "pcot_map.svh"
module pcot_top_tb;
  import pcot_pkg::*;
  localparam int unsigned HOLD = 20;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic req_valid = 1'b0;
  pcot_req_s req = '0;
  logic req_ready, req_err, tlp_valid, tlp_ready;
  pcot_tlp_s tlp, last_tlp, x;
  logic [1:0] power_state_field = 2'h0;
  logic pme_enable = 1'b0;
  logic [1:0] irq_status = 2'h0;
  logic [1:0] irq_enabled = 2'h0;
  logic pcie_inband_rst = 1'b0;
  logic stall = 1'b0;
  logic pme_o, cpu_irq, aux_force, beacon_o, wake_o, wake_oe;
  logic mac_rst, chip_rst, err;
  logic [7:0] n_tlp, p;
  logic [31:0] rdv;
  int fail_count = 0;
  int n_checks = 0;
  int n_pme = 0;
  int n_rst = 0;
  int q;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (pme_o === 1'b1) n_pme <= n_pme + 1;
    if (chip_rst === 1'b1) n_rst <= n_rst + 1;
  end
  pcot_top #(.RST_HOLD_CYC(HOLD)) i_pcot_top (
    .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .req_err(req_err), .tlp_valid(tlp_valid), .tlp(tlp),
    .tlp_ready(tlp_ready), .power_state_field(power_state_field), .pme_enable(pme_enable),
    .irq_status(irq_status), .irq_enabled(irq_enabled),
    .pcie_inband_rst(pcie_inband_rst), .pme_o(pme_o), .cpu_irq(cpu_irq),
    .aux_force(aux_force), .beacon_o(beacon_o), .wake_o(wake_o),
    .wake_oe(wake_oe), .mac_rst(mac_rst), .chip_rst(chip_rst)
  );
  pcot_rc_model i_pcot_rc_model (
    .clk_sys(clk_sys), .reset(reset), .stall(stall),
    .tlp_valid(tlp_valid), .tlp(tlp), .tlp_ready(tlp_ready),
    .last_tlp(last_tlp), .n_tlp(n_tlp)
  );
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: seen %h wanted %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    logic w;
    n = 0;
    w = 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
      w = avs_waitrequest;
      rdv = avs_readdata;
      n++;
    end while (w !== 1'b0 && n < 50);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk(w, 1'b0);
    repeat (2) @(posedge clk_sys);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdv, e);
  endtask : rd
  task automatic send(input logic [31:0] a, input logic dma);
    int n;
    logic r;
    n = 0;
    r = 1'b0;
    req <= '{addr: a, write: ~dma, from_dma: dma};
    req_valid <= 1'b1;
    do begin
      @(posedge clk_sys);
      r = req_ready;
      n++;
    end while (r !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    chk(r, 1'b1);
    @(posedge clk_sys);
    err = req_err;
    @(posedge clk_sys);
  endtask : send
  task automatic go(input logic [31:0] a, input logic dma, input logic e,
      input logic [63:0] t);
    send(a, dma);
    chk(err, e);
    if (e === 1'b0) chk(last_tlp.addr, t);
  endtask : go
  initial begin
    #100_000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(8'hfc, 32'h0000_0000);
    wr(`PCOT_OFS_SYSBUS_CFG, 32'h0000_0052);
    wr(`PCOT_OFS_REGION_SEL, 32'h0000_0000);
    wr(`PCOT_OFS_TLP_HDR, 32'h0000_0255);
    wr(`PCOT_OFS_REGION_CTL, 32'h0000_0020);
    wr(`PCOT_OFS_BASE_LOW, 32'h0000_0000);
    wr(`PCOT_OFS_LIMIT, 32'h0000_3fff);
    wr(`PCOT_OFS_TGT_LOW, 32'h0000_0012);
    wr(`PCOT_OFS_TGT_HIGH, 32'h0000_0001);
    go(32'hc000_1234, 1'b0, 1'b1, 64'h0);
    wr(`PCOT_OFS_REGION_CTL, 32'h8000_0020);
    go(32'hc000_1234, 1'b0, 1'b0, 64'h0000_0001_0012_1234);
    x = '{64'h0000_0001_0012_1234, 1'b1, 2'h1, 1'b1, 3'h5, 5'h02,
        8'h20, 1'b1, 4'h5};
    chk(last_tlp, x);
    // no dma traffic while its window moves
    wr(`PCOT_OFS_DMA_CFG, 32'h0000_0001);
    wr(`PCOT_OFS_REGION_SEL, 32'h0000_0001);
    wr(`PCOT_OFS_TLP_HDR, 32'h0000_0032);
    wr(`PCOT_OFS_REGION_CTL, 32'h8000_0000);
    wr(`PCOT_OFS_BASE_LOW, 32'h0000_4000);
    wr(`PCOT_OFS_LIMIT, 32'h0000_7fff);
    wr(`PCOT_OFS_TGT_LOW, 32'h0000_c000);
    wr(`PCOT_OFS_TGT_HIGH, 32'h0000_0000);
    go(32'hffff_fff0, 1'b1, 1'b0, 64'h0000_0000_ffff_fff0);
    x = '{64'h0000_0000_ffff_fff0, 1'b0, 2'h2, 1'b0, 3'h3, 5'h00,
        8'h00, 1'b0, `PCOT_BE_ALL};
    chk(last_tlp, x);
    go(32'hffff_fff0, 1'b0, 1'b0, 64'h0000_0001_4011_fff0);
    go(32'h8000_0000, 1'b0, 1'b1, 64'h0);
    wr(`PCOT_OFS_REGION_SEL, 32'h0000_0000);
    wr(`PCOT_OFS_TGT_LOW, 32'h0000_0100);
    wr(`PCOT_OFS_LIMIT, 32'h0000_0fff);
    go(32'hcfff_fffc, 1'b0, 1'b0, 64'h0000_0001_10ff_fffc);
    go(32'hd000_0000, 1'b0, 1'b1, 64'h0);
    go(32'hffff_fff0, 1'b1, 1'b0, 64'h0000_0000_ffff_fff0);
    stall <= 1'b1;
    p = n_tlp;
    send(32'hc000_0000, 1'b0);
    @(negedge clk_sys);
    chk({req_ready, tlp_valid, n_tlp}, {2'b01, p});
    @(posedge clk_sys);
    stall <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(last_tlp.addr, 64'h0000_0001_0100_0000);
    power_state_field <= `PCOT_PM_D3;
    repeat (3) @(posedge clk_sys);
    rd(`PCOT_OFS_PWR_STAT, 32'h0000_0003);
    rd(`PCOT_OFS_EV_STICKY, 32'h0000_0001);
    chk(cpu_irq, 1'b0);
    wr(`PCOT_OFS_EV_ENABLE, 32'h0000_0001);
    chk(cpu_irq, 1'b1);
    rd(`PCOT_OFS_IRQ_IDENT, 32'h0000_0001);
    wr(`PCOT_OFS_EV_STICKY, 32'h0000_0001);
    chk(cpu_irq, 1'b0);
    q = n_pme;
    go(32'hc000_0000, 1'b0, 1'b0, 64'h0000_0001_0100_0000);
    chk(n_pme - q, 0);
    pme_enable <= 1'b1;
    irq_enabled <= 2'h1;
    @(posedge clk_sys);
    q = n_pme;
    go(32'hc000_0000, 1'b0, 1'b0, 64'h0000_0001_0100_0000);
    irq_status <= 2'h1;
    repeat (3) @(posedge clk_sys);
    chk(n_pme - q, 2);
    wr(`PCOT_OFS_INTR_COMMON, 32'h0000_0001);
    q = n_pme;
    irq_status <= 2'h0;
    repeat (3) @(posedge clk_sys);
    chk(n_pme - q, 0);
    chk(beacon_o, 1'b1);
    wr(`PCOT_OFS_WAKE_CFG, 32'h0000_0001);
    chk({beacon_o, wake_o, wake_oe}, 3'b001);
    wr(`PCOT_OFS_WAKE_CFG, 32'h0000_0003);
    chk({beacon_o, wake_o, wake_oe}, 3'b011);
    wr(`PCOT_OFS_WAKE_CFG, 32'h0000_0007);
    chk({wake_o, wake_oe}, 2'b11);
    power_state_field <= `PCOT_PM_D0;
    repeat (3) @(posedge clk_sys);
    chk({beacon_o, wake_o, wake_oe}, 3'b000);
    wr(`PCOT_OFS_AUX_CFG, 32'h0000_0003);
    chk(aux_force, 1'b1);
    wr(`PCOT_OFS_AUX_CFG, 32'h0000_0002);
    chk(aux_force, 1'b0);
    pcie_inband_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({mac_rst, chip_rst}, 2'b10);
    rd(`PCOT_OFS_REGION_CTL, 32'h8000_0020);
    avs_byteenable <= 4'h1;
    wr(`PCOT_OFS_TGT_HIGH, 32'hffff_ff05);
    avs_byteenable <= 4'hf;
    rd(`PCOT_OFS_TGT_HIGH, 32'h0000_0005);
    pcie_inband_rst <= 1'b0;
    wr(`PCOT_OFS_SOFT_RST, 32'h0000_0001);
    repeat (HOLD + 10) @(posedge clk_sys);
    chk(n_rst, HOLD);
    rd(`PCOT_OFS_REGION_CTL, 32'h0000_0000);
    rd(`PCOT_OFS_SOFT_RST, 32'h0000_0000);
    go(32'hc000_0000, 1'b0, 1'b1, 64'h0);
    report_and_stop();
  end
endmodule : pcot_top_tb
`default_nettype wire

/* design/pcot_map.svh */
// constant map for the pcie outbound translation and power block
// assumes a 250 MHz core clock and 32-bit word registers
`ifndef PCOT_MAP_SVH
`define PCOT_MAP_SVH
`define PCOT_OFS_REGION_SEL 8'h00
`define PCOT_OFS_TLP_HDR 8'h04
`define PCOT_OFS_REGION_CTL 8'h08
`define PCOT_OFS_BASE_LOW 8'h0c
`define PCOT_OFS_LIMIT 8'h10
`define PCOT_OFS_TGT_LOW 8'h14
`define PCOT_OFS_TGT_HIGH 8'h18
`define PCOT_OFS_SYSBUS_CFG 8'h1c
`define PCOT_OFS_DMA_CFG 8'h20
`define PCOT_OFS_PWR_STAT 8'h24
`define PCOT_OFS_EV_STICKY 8'h28
`define PCOT_OFS_EV_ENABLE 8'h2c
`define PCOT_OFS_IRQ_IDENT 8'h30
`define PCOT_OFS_WAKE_CFG 8'h34
`define PCOT_OFS_AUX_CFG 8'h38
`define PCOT_OFS_INTR_COMMON 8'h3c
`define PCOT_OFS_SOFT_RST 8'h40
`define PCOT_WIN_SEL 2'h3
`define PCOT_AUX_FORCE 2'h3
`define PCOT_PM_D0 2'h0
`define PCOT_PM_D3 2'h3
`define PCOT_BE_ALL 4'hf
`define PCOT_TGT_SHIFT 16
`define PCOT_SOFT_RST_MS 100
`define PCOT_CLK_KHZ 250000
`define PCOT_RST_HOLD_CYC (`PCOT_SOFT_RST_MS * `PCOT_CLK_KHZ)
`endif

/* design/pcot_pkg.sv */
// types shared by the outbound translation block
// assumes pcot_map.svh supplies the numeric constants
package pcot_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic from_dma;
  } pcot_req_s;
  typedef struct packed {
    logic [63:0] addr;
    logic write;
    logic [1:0] attr;
    logic td;
    logic [2:0] tc;
    logic [4:0] ttype;
    logic [7:0] msg;
    logic poisoned;
    logic [3:0] be;
  } pcot_tlp_s;
  typedef struct packed {
    logic en;
    logic [1:0] attr;
    logic td;
    logic [2:0] tc;
    logic [4:0] ttype;
    logic [7:0] msg;
    logic [15:0] base;
    logic [15:0] limit;
    logic [15:0] tgt_lo;
    logic [31:0] tgt_hi;
  } pcot_region_s;
endpackage : pcot_pkg

/* design/pcot_region.sv */
// one address translation region: window match and address forming
// assumes its configuration comes from registers on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "pcot_map.svh"
module pcot_region (
  input wire logic clk_sys,
  input wire logic reset,
  input wire pcot_pkg::pcot_region_s cfg,
  input wire logic [31:0] addr,
  input wire logic offset_sel,
  output logic hit,
  output logic [63:0] paddr
);
  import pcot_pkg::*;
  logic [15:0] key;
  // source offset select sets key bit 14, lifting that source's keys by 0x4000
  assign key = {1'b0, offset_sel, addr[29:16]};
  assign hit = cfg.en && key >= cfg.base && key <= cfg.limit;
  // 64 kilobyte target plus low thirty address bits
  assign paddr = ({16'h0000, cfg.tgt_hi, cfg.tgt_lo} << `PCOT_TGT_SHIFT)
               + {34'h0, addr[29:0]};

  property p_region_off;
    @(posedge clk_sys) disable iff (reset)
      !cfg.en |-> !hit;
  endproperty
  a_region_off: assert property (p_region_off)
    else $error("disabled region reported a hit");
  property p_region_bounds;
    @(posedge clk_sys) disable iff (reset)
      hit |-> key <= cfg.limit && key >= cfg.base;
  endproperty
  a_region_bounds: assert property (p_region_bounds)
    else $error("hit outside base and limit");
endmodule : pcot_region
`default_nettype wire

/* design/pcot_top.sv */
// outbound pcie translation, power reporting, wake and soft reset
// assumes avalon-mm master, request source and tlp sink on clk_sys
`timescale 1ns/1ns
`default_nettype none
`include "pcot_map.svh"
module pcot_top #(
  parameter int unsigned RST_HOLD_CYC = `PCOT_RST_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output var logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic req_valid,
  input wire pcot_pkg::pcot_req_s req,
  output logic req_ready,
  output var logic req_err,
  output var logic tlp_valid,
  output var pcot_pkg::pcot_tlp_s tlp,
  input wire logic tlp_ready,
  input wire logic [1:0] power_state_field,
  input wire logic pme_enable,
  input wire logic [1:0] irq_status,
  input wire logic [1:0] irq_enabled,
  input wire logic pcie_inband_rst,
  output var logic pme_o,
  output logic cpu_irq,
  output logic aux_force,
  output var logic beacon_o,
  output var logic wake_o,
  output var logic wake_oe,
  output logic mac_rst,
  output logic chip_rst
);
  import pcot_pkg::*;

  pcot_region_s region_q [2];
  logic idx_q;
  logic sb_off_q, sb_poison_q, dma_off_q, no_wake_q;
  logic [3:0] sb_be_q;
  logic ev_q, ev_en_q;
  logic beacon_disable_q, wake_polarity_q, wake_od_q;
  logic [1:0] aux_q, pm_prev_q, irq_prev_q;
  logic soft_q, reinit, ack_q;
  logic [31:0] hold_cnt_q, rdata, wmerge;
  logic wr_go, ev_clr, acc, down, d3, trig;
  logic [1:0] hit;
  logic [63:0] paddr [2];
  pcot_region_s sel;
  pcot_tlp_s tlp_d;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // avalon slave: one wait cycle, then write lands and data stands
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_go = avs_write && ack_q;
  assign sel = region_q[idx_q];
  // byte lanes merged over the current field value
  assign wmerge = merge(rdata, avs_writedata, avs_byteenable);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    case (avs_address)
      `PCOT_OFS_REGION_SEL: rdata = {31'h0, idx_q};
      `PCOT_OFS_TLP_HDR:
        rdata = {19'h0, sel.ttype, 1'b0, sel.tc, 1'b0, sel.td, sel.attr};
      `PCOT_OFS_REGION_CTL: rdata = {sel.en, 23'h0, sel.msg};
      `PCOT_OFS_BASE_LOW: rdata = {16'h0, sel.base};
      `PCOT_OFS_LIMIT: rdata = {16'h0, sel.limit};
      `PCOT_OFS_TGT_LOW: rdata = {16'h0, sel.tgt_lo};
      `PCOT_OFS_TGT_HIGH: rdata = sel.tgt_hi;
      `PCOT_OFS_SYSBUS_CFG: rdata = {24'h0, sb_be_q, 2'h0, sb_poison_q, sb_off_q};
      `PCOT_OFS_DMA_CFG: rdata = {31'h0, dma_off_q};
      `PCOT_OFS_PWR_STAT: rdata = {30'h0, power_state_field};
      `PCOT_OFS_EV_STICKY: rdata = {31'h0, ev_q};
      `PCOT_OFS_EV_ENABLE: rdata = {31'h0, ev_en_q};
      `PCOT_OFS_IRQ_IDENT: rdata = {31'h0, cpu_irq};
      `PCOT_OFS_WAKE_CFG: rdata = {29'h0, wake_od_q, wake_polarity_q, beacon_disable_q};
      `PCOT_OFS_AUX_CFG: rdata = {30'h0, aux_q};
      `PCOT_OFS_INTR_COMMON: rdata = {31'h0, no_wake_q};
      `PCOT_OFS_SOFT_RST: rdata = {31'h0, soft_q};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rdata;
    end
  end

  // region registers, reached through the region index
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      region_q[0] <= '0;
      region_q[1] <= '0;
      idx_q <= 1'b0;
    end else if (reinit) begin
      region_q[0] <= '0;
      region_q[1] <= '0;
      idx_q <= 1'b0;
    end else if (wr_go) begin
      case (avs_address)
        `PCOT_OFS_REGION_SEL: idx_q <= avs_writedata[0];
        `PCOT_OFS_TLP_HDR: begin
          if (avs_byteenable[0]) begin
            region_q[idx_q].attr <= avs_writedata[1:0];
            region_q[idx_q].td <= avs_writedata[2];
            region_q[idx_q].tc <= avs_writedata[6:4];
          end
          if (avs_byteenable[1]) begin
            region_q[idx_q].ttype <= avs_writedata[12:8];
          end
        end
        `PCOT_OFS_REGION_CTL: begin
          if (avs_byteenable[0]) begin
            region_q[idx_q].msg <= avs_writedata[7:0];
          end
          if (avs_byteenable[3]) begin
            region_q[idx_q].en <= avs_writedata[31];
          end
        end
        `PCOT_OFS_BASE_LOW: region_q[idx_q].base <= wmerge[15:0];
        `PCOT_OFS_LIMIT: region_q[idx_q].limit <= wmerge[15:0];
        `PCOT_OFS_TGT_LOW: region_q[idx_q].tgt_lo <= wmerge[15:0];
        `PCOT_OFS_TGT_HIGH: region_q[idx_q].tgt_hi <= wmerge;
        default: ;
      endcase
    end
  end

  // loose configuration bits
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {sb_be_q, sb_poison_q, sb_off_q, dma_off_q} <= '0;
      {ev_en_q, no_wake_q, beacon_disable_q, wake_polarity_q, wake_od_q} <= '0;
      aux_q <= 2'h0;
    end else if (reinit) begin
      {sb_be_q, sb_poison_q, sb_off_q, dma_off_q} <= '0;
      {ev_en_q, no_wake_q, beacon_disable_q, wake_polarity_q, wake_od_q} <= '0;
      aux_q <= 2'h0;
    end else if (wr_go && avs_byteenable[0]) begin
      case (avs_address)
        `PCOT_OFS_SYSBUS_CFG: begin
          sb_off_q <= avs_writedata[0];
          sb_poison_q <= avs_writedata[1];
          sb_be_q <= avs_writedata[7:4];
        end
        `PCOT_OFS_DMA_CFG: dma_off_q <= avs_writedata[0];
        `PCOT_OFS_EV_ENABLE: ev_en_q <= avs_writedata[0];
        `PCOT_OFS_WAKE_CFG: begin
          beacon_disable_q <= avs_writedata[0];
          wake_polarity_q <= avs_writedata[1];
          wake_od_q <= avs_writedata[2];
        end
        `PCOT_OFS_AUX_CFG: aux_q <= avs_writedata[1:0];
        `PCOT_OFS_INTR_COMMON: no_wake_q <= avs_writedata[0];
        default: ;
      endcase
    end
  end

  assign aux_force = aux_q == `PCOT_AUX_FORCE;

  // translation regions
  for (genvar g = 0; g < 2; g++) begin : g_region
    pcot_region u_region (
      .clk_sys(clk_sys),
      .reset(reset),
      .cfg(region_q[g]),
      .addr(req.addr),
      .offset_sel(req.from_dma ? dma_off_q : sb_off_q),
      .hit(hit[g]),
      .paddr(paddr[g])
    );
  end

  // outbound request path, one tlp register
  assign req_ready = !tlp_valid || tlp_ready;
  assign acc = req_valid && req_ready;

  always_comb begin
    tlp_d = '0;
    tlp_d.write = req.write;
    if (hit[0]) begin
      tlp_d.addr = paddr[0];
      tlp_d.attr = region_q[0].attr;
      tlp_d.td = region_q[0].td;
      tlp_d.tc = region_q[0].tc;
      tlp_d.ttype = region_q[0].ttype;
      tlp_d.msg = region_q[0].msg;
    end else begin
      tlp_d.addr = paddr[1];
      tlp_d.attr = region_q[1].attr;
      tlp_d.td = region_q[1].td;
      tlp_d.tc = region_q[1].tc;
      tlp_d.ttype = region_q[1].ttype;
      tlp_d.msg = region_q[1].msg;
    end
    // poisoned and byte enables only for system bus sources
    tlp_d.poisoned = req.from_dma ? 1'b0 : sb_poison_q;
    tlp_d.be = req.from_dma ? `PCOT_BE_ALL : sb_be_q;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tlp_valid <= 1'b0;
      tlp <= '0;
      req_err <= 1'b0;
    end else begin
      req_err <= 1'b0;
      if (tlp_ready) begin
        tlp_valid <= 1'b0;
      end
      if (acc) begin
        if (req.addr[31:30] == `PCOT_WIN_SEL && |hit) begin
          tlp_valid <= 1'b1;
          tlp <= tlp_d;
        end else begin
          req_err <= 1'b1;
        end
      end
    end
  end

  // power state event, set beats clear
  assign ev_clr = wr_go && avs_address == `PCOT_OFS_EV_STICKY &&
                  avs_byteenable[0] && avs_writedata[0];
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ev_q <= 1'b0;
      pm_prev_q <= `PCOT_PM_D0;
    end else begin
      pm_prev_q <= power_state_field;
      if (power_state_field != pm_prev_q) begin
        ev_q <= 1'b1;
      end else if (ev_clr || reinit) begin
        ev_q <= 1'b0;
      end
    end
  end
  assign cpu_irq = ev_q && ev_en_q;

  // pme, beacon and wake
  assign down = power_state_field != `PCOT_PM_D0;
  assign d3 = power_state_field == `PCOT_PM_D3;
  assign trig = acc || (|((irq_status ^ irq_prev_q) & irq_enabled)
                        && !no_wake_q);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_prev_q <= 2'h0;
      pme_o <= 1'b0;
      beacon_o <= 1'b0;
      wake_o <= 1'b0;
      wake_oe <= 1'b0;
    end else begin
      irq_prev_q <= irq_status;
      pme_o <= pme_enable && down && trig;
      beacon_o <= d3 && !beacon_disable_q;
      wake_o <= (d3 && beacon_disable_q) ~^ wake_polarity_q;
      wake_oe <= beacon_disable_q && (!wake_od_q || d3);
    end
  end

  // in-band reset reaches the mac alone
  assign mac_rst = pcie_inband_rst;

  // soft chip reset, held then self clearing with reinit
  assign reinit = soft_q && hold_cnt_q == RST_HOLD_CYC - 1;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      soft_q <= 1'b0;
      hold_cnt_q <= 32'h0000_0000;
    end else if (reinit) begin
      soft_q <= 1'b0;
      hold_cnt_q <= 32'h0000_0000;
    end else if (soft_q) begin
      hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
    end else if (wr_go && avs_address == `PCOT_OFS_SOFT_RST &&
                 avs_byteenable[0] && avs_writedata[0]) begin
      soft_q <= 1'b1;
    end
  end
  assign chip_rst = soft_q;

  sequence s_soft_wr;
    wr_go && avs_address == `PCOT_OFS_SOFT_RST && avs_byteenable[0]
      && avs_writedata[0] && !soft_q;
  endsequence
  property p_soft_hold;
    @(posedge clk_sys) disable iff (reset)
      s_soft_wr |=> chip_rst [*2];
  endproperty
  a_soft_hold: assert property (p_soft_hold)
    else $error("soft reset not held after write");
  property p_pme_req;
    @(posedge clk_sys) disable iff (reset)
      acc && pme_enable && down |=> pme_o;
  endproperty
  a_pme_req: assert property (p_pme_req)
    else $error("pme missing after request while down");
  property p_pme_d0;
    @(posedge clk_sys) disable iff (reset)
      pme_o |-> $past(power_state_field) != `PCOT_PM_D0 && $past(pme_enable);
  endproperty
  a_pme_d0: assert property (p_pme_d0)
    else $error("pme while powered up or disabled");
  property p_pm_event;
    @(posedge clk_sys) disable iff (reset)
      power_state_field != pm_prev_q |=> ev_q
        ##1 (ev_q || $past(ev_clr) || $past(reinit));
  endproperty
  a_pm_event: assert property (p_pm_event)
    else $error("power state change did not set event");
  property p_irq_gate;
    @(posedge clk_sys) disable iff (reset)
      cpu_irq |-> ev_q && ev_en_q;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without enabled event");
  property p_xlate0;
    @(posedge clk_sys) disable iff (reset)
      acc && hit[0] && req.addr[31:30] == `PCOT_WIN_SEL
        |=> tlp_valid && tlp.addr == $past(paddr[0]);
  endproperty
  a_xlate0: assert property (p_xlate0)
    else $error("region zero address not translated");
  property p_miss;
    @(posedge clk_sys) disable iff (reset)
      acc && !(|hit) |=> req_err && !tlp_valid;
  endproperty
  a_miss: assert property (p_miss)
    else $error("unmatched request produced a tlp");
  property p_beacon;
    @(posedge clk_sys) disable iff (reset)
      d3 && !beacon_disable_q |=> beacon_o && wake_o != $past(wake_polarity_q);
  endproperty
  a_beacon: assert property (p_beacon)
    else $error("beacon or wake wrong in d3");
  property p_wake;
    @(posedge clk_sys) disable iff (reset)
      d3 && beacon_disable_q |=> !beacon_o && wake_o == $past(wake_polarity_q)
        && wake_oe;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake not driven at polarity");
endmodule : pcot_top
`default_nettype wire
